// ===== smc_map.vh
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
// bank width field codes
`define WIDTH_8 2'b00
`define WIDTH_16 2'b01
`define WIDTH_32 2'b10
// per-bank config word layout
`define CFG_READ_WAIT_HI 9
`define CFG_READ_WAIT_LO 5
`define CFG_READ_LANE_BIT 10
`define CFG_WRITE_WAIT_HI 15
`define CFG_WRITE_WAIT_LO 11
`define CFG_WIDTH_HI 29
`define CFG_WIDTH_LO 28
// pin function select two: low address pin selects
`define PSEL_ADDR0_BIT 24
`define PSEL_ADDR1_BIT 23
// fixed phase lengths in core cycles
`define READ_EXTRA_CYCLES 6'h02
`define WRITE_HOLD_EXTRA 6'h01
// reset values
`define CFG_RESET 32'h0000FBEF
`define ADDR_RESET 24'h000000
`endif

// ===== smc_clock_out.v
`timescale 1ns/1ps
`include "smc_map.vh"
// -----------------------------------------------------------------
// external bus clock generator
// -----------------------------------------------------------------
module smc_clock_out
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire enable_in,
    output reg bus_clk_out
);
    // half-rate toggle; a flop cannot follow the core clock at full rate,
    // so the reference runs at half the core rate, low while disabled
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            bus_clk_out <= 1'b0;
        else if (enable_in)
            bus_clk_out <= ~bus_clk_out;
        else
            bus_clk_out <= 1'b0;
    end
endmodule

// ===== static_memory_bus_interface.v
`timescale 1ns/1ps
`include "smc_map.vh"
// Operation
// - read lane setting chosen to suit parts
// - bank width decides which low address bits matter
// - optional bus clock output from core clock
// - first read after bank change starts early
// - non-final burst writes hold data longer
// - read lane setting drives lane selects polarity
// - width codes: 8, 16, 32 bit, reserved
// - read length equals read wait plus three
// - write: setup, wait plus one, hold
module static_memory_bus_interface
#(
    parameter ADDR_W = 24
)
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [31:0] bank_config_register_in,
    input wire [31:0] pin_function_select_two_in,
    input wire bus_clk_enable_in,
    input wire req_in,
    input wire req_write_in,
    input wire [1:0] req_bank_in,
    input wire [ADDR_W-1:0] req_addr_in,
    input wire [1:0] req_size_in,
    input wire [31:0] req_wdata_in,
    input wire req_more_writes_in,
    input wire [31:0] mem_rdata_in,
    output reg busy_out,
    output reg done_out,
    output reg [31:0] rdata_out,
    output reg [ADDR_W-1:0] mem_addr_out,
    output reg [3:0] chip_select_n_out,
    output reg output_enable_n_out,
    output reg write_enable_n_out,
    output reg [3:0] byte_lane_select_lines_n_out,
    output reg [31:0] mem_wdata_out,
    output reg mem_wdata_oe_out,
    output reg address_bit_zero_is_addr_out,
    output reg address_bit_one_is_addr_out,
    output wire external_bus_clock_out
);
    // -------------------------------------------------------------
    // state encoding
    // -------------------------------------------------------------
    localparam ST_IDLE = 3'b000;
    localparam ST_RSETUP = 3'b001;
    localparam ST_READ = 3'b010;
    localparam ST_WSETUP = 3'b011;
    localparam ST_WSTROBE = 3'b100;
    localparam ST_WHOLD = 3'b101;
    localparam ST_NEXT = 3'b110;

    // bytes carried per external access for a width code
    function [2:0] bytes_per_beat;
        input [1:0] width;
        begin
            case (width)
                `WIDTH_8: bytes_per_beat = 3'h1;
                `WIDTH_16: bytes_per_beat = 3'h2;
                default: bytes_per_beat = 3'h4; // reserved code treated as 32-bit
            endcase
        end
    endfunction

    // active-low lane enables for one beat of a write
    function [3:0] lane_mask_n;
        input [1:0] width;
        input [1:0] lane;
        begin
            case (width)
                `WIDTH_8: lane_mask_n = 4'hE;
                `WIDTH_16: lane_mask_n = 4'hC;
                default: lane_mask_n = ~(4'hF >> (3'h4 - {1'b0, lane}));
            endcase
        end
    endfunction

    // -------------------------------------------------------------
    // state registers
    // -------------------------------------------------------------
    reg [2:0] state_reg; // controller phase
    reg [5:0] count_reg; // cycles left in phase, wide enough for read wait plus two
    reg [2:0] bytes_left_reg; // bytes still to move
    reg [2:0] byte_pos_reg; // byte offset into internal word
    reg [1:0] last_bank_reg; // bank of previous access
    reg bank_valid_reg; // a bank has been used
    reg write_run_reg; // more writes follow this one
    reg [31:0] rshift_reg; // assembled read data
    reg [31:0] wword_reg; // held write word
    reg [1:0] width_reg; // latched bank width
    reg [4:0] rwait_reg; // latched read wait
    reg [4:0] wwait_reg; // latched write wait
    reg lane_read_reg; // latched read lane setting
    reg [1:0] cur_bank_reg; // bank of current access
    reg [1:0] size_reg; // latched transfer size code

    wire [1:0] cfg_width = bank_config_register_in[`CFG_WIDTH_HI:`CFG_WIDTH_LO];
    wire [2:0] beat_bytes = bytes_per_beat(width_reg);
    wire [2:0] req_bytes = (req_size_in == 2'b00) ? 3'h1 : ((req_size_in == 2'b01) ? 3'h2 : 3'h4);

    // -------------------------------------------------------------
    // pin function selects and bus clock
    // -------------------------------------------------------------
    // registered so outputs come from flops
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            address_bit_zero_is_addr_out <= 1'b0;
            address_bit_one_is_addr_out <= 1'b0;
        end
        else
        begin
            address_bit_zero_is_addr_out <= pin_function_select_two_in[`PSEL_ADDR0_BIT];
            address_bit_one_is_addr_out <= pin_function_select_two_in[`PSEL_ADDR1_BIT];
        end
    end

    // bus clock helper; the generated clock is used as a timing reference only
    smc_clock_out clock_gen
    (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .enable_in(bus_clk_enable_in),
        .bus_clk_out(external_bus_clock_out)
    );

    // -------------------------------------------------------------
    // access sequencer
    // -------------------------------------------------------------
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 6'h00;
            bytes_left_reg <= 3'h0;
            byte_pos_reg <= 3'h0;
            last_bank_reg <= 2'b00;
            bank_valid_reg <= 1'b0;
            write_run_reg <= 1'b0;
            rshift_reg <= 32'h00000000;
            wword_reg <= 32'h00000000;
            width_reg <= `WIDTH_32;
            rwait_reg <= 5'h00;
            wwait_reg <= 5'h00;
            lane_read_reg <= 1'b0;
            cur_bank_reg <= 2'b00;
            size_reg <= 2'b00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 32'h00000000;
            mem_addr_out <= `ADDR_RESET;
            chip_select_n_out <= 4'hF;
            output_enable_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
            byte_lane_select_lines_n_out <= 4'hF;
            mem_wdata_out <= 32'h00000000;
            mem_wdata_oe_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    chip_select_n_out <= 4'hF;
                    output_enable_n_out <= 1'b1;
                    write_enable_n_out <= 1'b1;
                    byte_lane_select_lines_n_out <= 4'hF;
                    mem_wdata_oe_out <= 1'b0;
                    if (req_in)
                    begin
                        busy_out <= 1'b1;
                        width_reg <= cfg_width;
                        rwait_reg <= bank_config_register_in[`CFG_READ_WAIT_HI:`CFG_READ_WAIT_LO];
                        wwait_reg <= bank_config_register_in[`CFG_WRITE_WAIT_HI:`CFG_WRITE_WAIT_LO];
                        lane_read_reg <= bank_config_register_in[`CFG_READ_LANE_BIT];
                        cur_bank_reg <= req_bank_in;
                        size_reg <= req_size_in;
                        bytes_left_reg <= req_bytes;
                        byte_pos_reg <= 3'h0;
                        wword_reg <= req_wdata_in;
                        rshift_reg <= 32'h00000000;
                        write_run_reg <= req_write_in & req_more_writes_in;
                        if (!req_write_in && (~bank_valid_reg | (last_bank_reg != req_bank_in)))
                        begin
                            chip_select_n_out <= ~(4'h1 << req_bank_in);
                            output_enable_n_out <= 1'b0;
                            byte_lane_select_lines_n_out <= {4{~bank_config_register_in[`CFG_READ_LANE_BIT]}};
                        end
                        last_bank_reg <= req_bank_in;
                        bank_valid_reg <= 1'b1;
                        // low bits dropped for wide banks, kept for 8-bit
                        case (cfg_width)
                            `WIDTH_8: mem_addr_out <= req_addr_in;
                            `WIDTH_16: mem_addr_out <= {req_addr_in[ADDR_W-1:1], 1'b0};
                            default: mem_addr_out <= {req_addr_in[ADDR_W-1:2], 2'b00};
                        endcase
                        state_reg <= req_write_in ? ST_WSETUP : ST_RSETUP;
                    end
                end
                ST_RSETUP:
                begin
                    // ordinary read drops select here; a fresh bank did so at accept, same end
                    chip_select_n_out <= ~(4'h1 << cur_bank_reg);
                    output_enable_n_out <= 1'b0;
                    byte_lane_select_lines_n_out <= lane_read_reg ? 4'h0 : 4'hF;
                    count_reg <= {1'b0, rwait_reg} + `READ_EXTRA_CYCLES;
                    state_reg <= ST_READ;
                end
                ST_READ:
                begin
                    if (count_reg != 6'h00)
                        count_reg <= count_reg - 6'h01;
                    else
                    begin
                        // sample at end of full read length only
                        case (width_reg)
                            `WIDTH_8: rshift_reg <= rshift_reg | ({24'h000000, mem_rdata_in[7:0]} << {byte_pos_reg, 3'b000});
                            `WIDTH_16: rshift_reg <= rshift_reg | ({16'h0000, mem_rdata_in[15:0]} << {byte_pos_reg, 3'b000});
                            default: rshift_reg <= mem_rdata_in;
                        endcase
                        chip_select_n_out <= 4'hF;
                        output_enable_n_out <= 1'b1;
                        byte_lane_select_lines_n_out <= 4'hF;
                        state_reg <= ST_NEXT;
                    end
                end
                ST_WSETUP:
                begin
                    // setup: address valid, strobes high
                    chip_select_n_out <= 4'hF;
                    write_enable_n_out <= 1'b1;
                    byte_lane_select_lines_n_out <= 4'hF;
                    mem_wdata_out <= wword_reg >> {byte_pos_reg, 3'b000};
                    mem_wdata_oe_out <= 1'b1;
                    count_reg <= {1'b0, wwait_reg}; // wait plus one strobe cycles
                    state_reg <= ST_WSTROBE;
                end
                ST_WSTROBE:
                begin
                    chip_select_n_out <= ~(4'h1 << cur_bank_reg);
                    write_enable_n_out <= 1'b0;
                    byte_lane_select_lines_n_out <= (bytes_left_reg < beat_bytes) ?
                        lane_mask_n(width_reg, bytes_left_reg[1:0]) : lane_mask_n(width_reg, 2'b00);
                    if (count_reg != 6'h00)
                        count_reg <= count_reg - 6'h01;
                    else
                    begin
                        // hold cycle, longer inside a write run
                        count_reg <= write_run_reg ? `WRITE_HOLD_EXTRA : 6'h00;
                        state_reg <= ST_WHOLD;
                    end
                end
                ST_WHOLD:
                begin
                    write_enable_n_out <= 1'b1;
                    byte_lane_select_lines_n_out <= 4'hF; // only select low here
                    if (count_reg != 6'h00)
                        count_reg <= count_reg - 6'h01;
                    else
                        state_reg <= ST_NEXT;
                end
                ST_NEXT:
                begin
                    chip_select_n_out <= 4'hF;
                    write_enable_n_out <= 1'b1;
                    if (bytes_left_reg > beat_bytes)
                    begin
                        // split wide access into next narrow bank address
                        bytes_left_reg <= bytes_left_reg - beat_bytes;
                        byte_pos_reg <= byte_pos_reg + beat_bytes;
                        mem_addr_out <= mem_addr_out + {{(ADDR_W-3){1'b0}}, beat_bytes};
                        state_reg <= mem_wdata_oe_out ? ST_WSETUP : ST_RSETUP;
                    end
                    else
                    begin
                        rdata_out <= rshift_reg;
                        done_out <= 1'b1;
                        busy_out <= 1'b0;
                        mem_wdata_oe_out <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== smc_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// static memory part behind the bus
// ----------------------------------------
module smc_mem_model
#(
    parameter ACC_NS = 8
)
(
    input wire ref_clk_in,
    input wire [1:0] width_in,
    input wire [23:0] addr_in,
    input wire [3:0] cs_n_in,
    input wire oe_n_in,
    input wire we_n_in,
    input wire [31:0] wdata_in,
    output wire [31:0] rdata_out
);
    reg [7:0] mem [0:255]; // small byte store
    reg [31:0] last_reg; // last driven word
    integer i;
    // unused low address bits are masked, as real wiring ignores them
    wire [7:0] mask = (width_in == 2'h0) ? 8'hFF : (width_in == 2'h1) ? 8'hFE : 8'hFC;
    wire [7:0] base = addr_in[7:0] & mask;
    wire [31:0] word = {mem[base + 8'h03], mem[base + 8'h02], mem[base + 8'h01], mem[base]};
    wire sel = !(&cs_n_in) && !oe_n_in;
    // lane selects ignored on reads; deselected bus shows inverted junk
    assign #(ACC_NS) rdata_out = sel ? word : ~last_reg;
    // capture each lane of the bank width while strobed
    always @(posedge ref_clk_in)
    begin
        if (sel)
            last_reg <= word;
        if (!(&cs_n_in) && !we_n_in)
            for (i = 0; i < (1 << width_in); i = i + 1)
                mem[base + i] <= wdata_in[8 * i +: 8];
    end
endmodule

// ===== smc_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// port-level checks
// ----------------------------------------
module smc_props
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [31:0] bank_config_register_in,
    input wire [31:0] pin_function_select_two_in,
    input wire bus_clk_enable_in,
    input wire req_in,
    input wire busy_out,
    input wire done_out,
    input wire [3:0] chip_select_n_out,
    input wire output_enable_n_out,
    input wire write_enable_n_out,
    input wire [3:0] byte_lane_select_lines_n_out,
    input wire mem_wdata_oe_out,
    input wire address_bit_zero_is_addr_out,
    input wire address_bit_one_is_addr_out,
    input wire external_bus_clock_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    reg [5:0] we_low_reg; // strobe low lengths
    reg [5:0] oe_low_reg;
    reg busy_d_reg; // busy one edge ago
    reg early_reg; // read strobe dropped at the accept edge
    wire [5:0] rw = {1'b0, bank_config_register_in[9:5]};
    wire [5:0] ww = {1'b0, bank_config_register_in[15:11]};
    // count low cycles of each strobe
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            we_low_reg <= 6'h00;
            oe_low_reg <= 6'h00;
            busy_d_reg <= 1'b0;
            early_reg <= 1'b0;
        end
        else
        begin
            we_low_reg <= write_enable_n_out ? 6'h00 : we_low_reg + 6'h01;
            oe_low_reg <= output_enable_n_out ? 6'h00 : oe_low_reg + 6'h01;
            busy_d_reg <= busy_out;
            // strobe low before busy was seen means the fresh-bank early start
            if (!output_enable_n_out && oe_low_reg == 6'h00)
                early_reg <= !busy_d_reg;
        end
    end
    done_pulse_a: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
    accept_busy_a: assert property (req_in && !busy_out && !done_out |=> busy_out) else $error("request not taken");
    op_ends_a: assert property ($rose(busy_out) |-> ##[1:300] done_out) else $error("operation hangs");
    lane_high_a: assert property (!output_enable_n_out && !bank_config_register_in[10]
        |-> byte_lane_select_lines_n_out == 4'hF) else $error("lanes low on read");
    lane_low_a: assert property (!output_enable_n_out && bank_config_register_in[10]
        |-> byte_lane_select_lines_n_out != 4'hF) else $error("lanes high on read");
    strobe_excl_a: assert property (output_enable_n_out || write_enable_n_out) else $error("both strobes low");
    write_setup_a: assert property ($fell(write_enable_n_out) |-> $past(&chip_select_n_out))
        else $error("no write setup cycle");
    write_len_a: assert property ($rose(write_enable_n_out) |-> we_low_reg == ww + 6'h01
        && !(&chip_select_n_out) && byte_lane_select_lines_n_out == 4'hF) else $error("write phase wrong");
    read_len_a: assert property ($rose(output_enable_n_out) |-> oe_low_reg == rw + 6'h03
        + {5'h00, early_reg}) else $error("read strobe length wrong");
    pin_sel_a: assert property ($past(rst_n_in) |-> {address_bit_zero_is_addr_out, address_bit_one_is_addr_out}
        == $past(pin_function_select_two_in[24:23])) else $error("low pin function wrong");
    clk_idle_a: assert property (!bus_clk_enable_in && !$past(bus_clk_enable_in) |-> !external_bus_clock_out)
        else $error("bus clock runs when off");
    clk_run_a: assert property ($past(rst_n_in) && bus_clk_enable_in && $past(bus_clk_enable_in)
        |-> external_bus_clock_out != $past(external_bus_clock_out)) else $error("bus clock stuck");
    data_drive_a: assert property (!write_enable_n_out |-> mem_wdata_oe_out)
        else $error("write strobe without data drive");
    no_fight_a: assert property (!output_enable_n_out |-> !mem_wdata_oe_out)
        else $error("data driven during read");
endmodule
bind static_memory_bus_interface smc_props u_props (.ref_clk_in, .rst_n_in, .bank_config_register_in,
    .pin_function_select_two_in, .bus_clk_enable_in, .req_in, .busy_out, .done_out, .chip_select_n_out,
    .output_enable_n_out, .write_enable_n_out, .byte_lane_select_lines_n_out, .mem_wdata_oe_out,
    .address_bit_zero_is_addr_out, .address_bit_one_is_addr_out, .external_bus_clock_out);

// ===== tb_static_memory_bus_interface.sv
`timescale 1ns/1ps
`define CHECK(n, e, g) begin n_compared = n_compared + 1; if ((g) !== (e)) begin fails = fails + 1; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_static_memory_bus_interface;
    // ----------------------------------------
    // stimulus and scoreboard
    // ----------------------------------------
    reg ref_clk_in = 0, rst_n_in = 0, bus_clk_enable_in = 0, req_in = 0, req_write_in = 0, req_more_writes_in = 0;
    reg [31:0] bank_config_register_in = 0, pin_function_select_two_in = 0, req_wdata_in = 0;
    reg [1:0] req_bank_in = 0, req_size_in = 2'h2;
    reg [23:0] req_addr_in = 0;
    wire [31:0] mem_rdata_in, rdata_out, mem_wdata_out;
    wire [23:0] mem_addr_out;
    wire [3:0] chip_select_n_out, byte_lane_select_lines_n_out;
    wire busy_out, done_out, output_enable_n_out, write_enable_n_out, mem_wdata_oe_out;
    wire address_bit_zero_is_addr_out, address_bit_one_is_addr_out, external_bus_clock_out;
    integer fails = 0, n_compared = 0, cyc, t1, t2, j, oel;
    reg x0;
    always #5 ref_clk_in = ~ref_clk_in;
    static_memory_bus_interface DUT (.ref_clk_in, .rst_n_in, .bank_config_register_in, .pin_function_select_two_in,
        .bus_clk_enable_in, .req_in, .req_write_in, .req_bank_in, .req_addr_in, .req_size_in, .req_wdata_in,
        .req_more_writes_in, .mem_rdata_in, .busy_out, .done_out, .rdata_out, .mem_addr_out, .chip_select_n_out,
        .output_enable_n_out, .write_enable_n_out, .byte_lane_select_lines_n_out, .mem_wdata_out,
        .mem_wdata_oe_out, .address_bit_zero_is_addr_out, .address_bit_one_is_addr_out, .external_bus_clock_out);
    smc_mem_model u_mem (.ref_clk_in(ref_clk_in), .width_in(bank_config_register_in[29:28]),
        .addr_in(mem_addr_out), .cs_n_in(chip_select_n_out), .oe_n_in(output_enable_n_out),
        .we_n_in(write_enable_n_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
    // config word: width, read wait, write wait, read lane bit
    function [31:0] cfg(input [1:0] wd, input [4:0] rw, input [4:0] ww, input ln);
        cfg = {2'h0, wd, 12'h000, ww, ln, rw, 5'h0F};
    endfunction
    task complete_run;
    begin
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // one request, held for one edge; waits for done, cycles in cyc
    task op(input w, input [1:0] b, input [23:0] a, input [31:0] d, input m);
        integer i;
    begin
        @(negedge ref_clk_in);
        {req_write_in, req_bank_in, req_addr_in, req_wdata_in, req_more_writes_in, req_in} = {w, b, a, d, m, 1'b1};
        @(negedge ref_clk_in);
        req_in = 0;
        cyc = 1;
        // oel counts falling edges that see the read strobe low
        oel = (output_enable_n_out === 1'b0);
        for (i = 0; i < 400 && done_out !== 1'b1; i = i + 1)
        begin
            @(negedge ref_clk_in);
            cyc = cyc + 1;
            oel = oel + (output_enable_n_out === 1'b0);
        end
        if (done_out !== 1'b1)
        begin
            fails = fails + 1;
            complete_run;
        end
    end
    endtask
    initial
    begin
        repeat (16) @(negedge ref_clk_in);
        rst_n_in = 1;
        `CHECK("cs_idle", 4'hF, chip_select_n_out)
        pin_function_select_two_in = 32'h01000000;
        repeat (2) @(negedge ref_clk_in);
        `CHECK("a0_fn", 2'h2, {address_bit_zero_is_addr_out, address_bit_one_is_addr_out})
        $display("test pins done");
        // width codes 8, 16 and 32 bit, read lane bit both ways, wide word split
        for (j = 0; j < 3; j = j + 1)
        begin
            bank_config_register_in = cfg(j, 5'h01, 5'h00, j > 0);
            op(1, 0, 24'h40, 32'hA1B2C3D4, 0);
            op(0, 0, 24'h40, 0, 0);
            `CHECK("rd_width", 32'hA1B2C3D4, rdata_out)
        end
        $display("test widths done");
        bank_config_register_in = cfg(2'h2, 5'h01, 5'h01, 1'b1);
        op(1, 0, 24'h80, 32'h11112222, 1);
        t1 = cyc;
        op(1, 0, 24'h84, 32'h33334444, 0);
        `CHECK("burst_hold", 1, t1 - cyc)
        op(0, 0, 24'h80, 0, 0);
        `CHECK("burst_rd0", 32'h11112222, rdata_out)
        op(0, 0, 24'h84, 0, 0);
        `CHECK("burst_rd1", 32'h33334444, rdata_out)
        bank_config_register_in = cfg(2'h2, 5'h01, 5'h04, 1'b0);
        op(1, 0, 24'h88, 32'h0, 0);
        `CHECK("write_len", 3, cyc - t1 + 1)
        $display("test writes done");
        op(0, 1, 24'h80, 0, 0);
        op(0, 0, 24'h80, 0, 0);
        t1 = oel;
        op(0, 0, 24'h80, 0, 0);
        t2 = cyc;
        `CHECK("first_rd", 1, t1 - oel)
        `CHECK("read_oe", 4, oel)
        bank_config_register_in = cfg(2'h2, 5'h04, 5'h04, 1'b0);
        op(0, 0, 24'h80, 0, 0);
        `CHECK("read_len", 3, cyc - t2)
        $display("test reads done");
        bus_clk_enable_in = 1;
        repeat (4) @(negedge ref_clk_in);
        x0 = external_bus_clock_out;
        @(negedge ref_clk_in);
        `CHECK("bus_clk", 1'b1, x0 ^ external_bus_clock_out)
        bus_clk_enable_in = 0;
        repeat (3) @(negedge ref_clk_in);
        `CHECK("bus_clk_off", 1'b0, external_bus_clock_out)
        $display("test clock done");
        complete_run;
    end
endmodule
